// File: inc/pats_pkg.sv
`default_nettype none

package pats_pkg;

  // Register byte addresses on the APB side.
  localparam logic [7:0] ADDR_OPT_A = 8'h00;
  localparam logic [7:0] ADDR_OPT_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_DTW   = 8'h0c;
  localparam logic [7:0] ADDR_STS   = 8'h10;
  localparam logic [7:0] ADDR_MSK   = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;

  // Field positions shared by both trigger option registers; NARROW is in the first only.
  localparam int unsigned VALLEY_EN = 0;
  localparam int unsigned CREST_EN  = 1;
  localparam int unsigned CMP0_EN   = 2;
  localparam int unsigned CMP1_EN   = 3;
  localparam int unsigned CMP0_PH   = 4;
  localparam int unsigned CMP1_PH   = 5;
  localparam int unsigned NARROW    = 6;

  localparam logic [7:0] OPT_A_MASK = 8'h7f;
  localparam logic [7:0] OPT_B_MASK = 8'h3f;
  localparam logic [7:0] OPT_RST    = 8'h00;
  localparam logic [7:0] DTW_RST    = 8'h00;
  localparam logic [7:0] DT_STEP    = 8'h01;
  localparam logic [7:0] DT_ZERO    = 8'h00;

  localparam int unsigned CTRL_CE    = 0;
  localparam int unsigned STS_TRIG_A = 0;
  localparam int unsigned STS_TRIG_B = 1;
  localparam int unsigned STS_W      = 2;
  localparam logic [STS_W-1:0] STS_RST = 2'h0;

  typedef enum logic [1:0] {
    DT_IDLE = 2'b00,
    DT_UP   = 2'b01,
    DT_DOWN = 2'b10
  } pats_dt_e;

endpackage : pats_pkg

`default_nettype wire

// File: core/pats_trig_sel.sv
`default_nettype none

module pats_trig_sel
  import pats_pkg::*;
(
  input  wire logic [7:0] opt_i,
  input  wire logic       cmp1_i,
  input  wire logic       cmp0_i,
  input  wire logic       crest_i,
  input  wire logic       valley_i,
  input  wire logic       dt_up_i,
  input  wire logic       dt_down_i,
  output logic            fire_o
);

  logic cmp1_ok;
  logic cmp0_ok;

  // Compare events only count in the chosen dead-time phase.
  assign cmp1_ok = opt_i[CMP1_PH] ? dt_down_i : dt_up_i;
  assign cmp0_ok = opt_i[CMP0_PH] ? dt_down_i : dt_up_i;

  assign fire_o = (cmp1_i & opt_i[CMP1_EN] & cmp1_ok)
                | (cmp0_i & opt_i[CMP0_EN] & cmp0_ok)
                | (crest_i & opt_i[CREST_EN])
                | (valley_i & opt_i[VALLEY_EN]);

endmodule // pats_trig_sel

`default_nettype wire

// File: core/pats_top.sv
// Notes on behaviour
// - Trigger A compare-1: mode 0 fires in dead-time up phase, 1 in down.
// - Trigger A compare-0: mode 0 fires in dead-time up phase, 1 in down.
// - Compare-1 event drives trigger A only when its enable bit is set.
// - Compare-0 event drives trigger A only when its enable bit is set.
// - Crest event drives trigger A when crest enable is set, else suppressed.
// - Valley event drives trigger A when valley enable is set, else suppressed.
// - Trigger B has its own four event enables in the second register.
// - Second option register accepts writes while timer count is enabled.
// - Reset clears the second option register to zero.
// - Second option register allows byte and single-bit software access.
// - Narrow mode: short pulse makes dead-time counter reverse and count down.
`default_nettype none

module pats_top
  import pats_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  input  wire logic        companion_compare1_event_i,
  input  wire logic        companion_compare0_event_i,
  input  wire logic        crest_event_i,
  input  wire logic        valley_event_i,
  input  wire logic        phase_out_i,
  output logic             adc_trigger_out_a_o,
  output logic             adc_trigger_out_b_o,
  output logic             irq_o
);

  import pats_pkg::*;

  typedef struct packed {
    logic [7:0]       opt_a;
    logic [7:0]       opt_b;
    logic             ce;
    logic [7:0]       dtw;
    logic [7:0]       dt_cnt;
    pats_dt_e         dt_st;
    logic             phase_prev;
    logic             trig_a;
    logic             trig_b;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] msk;
    logic [31:0]      prdata;
  } pats_state_s;

  pats_state_s state_ff;
  pats_state_s nxt_state;

  logic       setup_ph;
  logic       wr_acc;
  logic       mapped;
  logic       dt_up;
  logic       dt_down;
  logic       phase_edge;
  logic       fire_a;
  logic       fire_b;
  logic [7:0] wbyte;
  logic [7:0] opt_a_new;

  assign setup_ph   = psel_i & ~penable_i;
  assign wr_acc     = psel_i & penable_i & pwrite_i;
  assign mapped     = (paddr_i == ADDR_OPT_A) || (paddr_i == ADDR_OPT_B)
                   || (paddr_i == ADDR_CTRL)  || (paddr_i == ADDR_DTW)
                   || (paddr_i == ADDR_STS)   || (paddr_i == ADDR_MSK)
                   || (paddr_i == ADDR_STATE);
  assign wbyte      = pwdata_i[7:0];
  assign dt_up      = state_ff.dt_st == DT_UP;
  assign dt_down    = state_ff.dt_st == DT_DOWN;
  assign phase_edge = phase_out_i ^ state_ff.phase_prev;

  // The slave never waits; an unmapped address is flagged in the access phase.
  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o  = state_ff.prdata;

  assign adc_trigger_out_a_o = state_ff.trig_a;
  assign adc_trigger_out_b_o = state_ff.trig_b;
  assign irq_o               = |(state_ff.sts & state_ff.msk);

  pats_trig_sel u_sel_a (
    .opt_i     (state_ff.opt_a),
    .cmp1_i    (companion_compare1_event_i),
    .cmp0_i    (companion_compare0_event_i),
    .crest_i   (crest_event_i),
    .valley_i  (valley_event_i),
    .dt_up_i   (dt_up),
    .dt_down_i (dt_down),
    .fire_o    (fire_a)
  );

  pats_trig_sel u_sel_b (
    .opt_i     (state_ff.opt_b),
    .cmp1_i    (companion_compare1_event_i),
    .cmp0_i    (companion_compare0_event_i),
    .crest_i   (crest_event_i),
    .valley_i  (valley_event_i),
    .dt_up_i   (dt_up),
    .dt_down_i (dt_down),
    .fire_o    (fire_b)
  );

  always_comb
  begin
    nxt_state = state_ff;
    opt_a_new = wbyte & OPT_A_MASK;
    // The narrow-mode bit would upset a running dead-time count, so it holds.
    if (state_ff.ce)
    begin
      opt_a_new[NARROW] = state_ff.opt_a[NARROW];
    end

    nxt_state.phase_prev = phase_out_i;
    nxt_state.trig_a     = state_ff.ce & fire_a;
    nxt_state.trig_b     = state_ff.ce & fire_b;

    if (!state_ff.ce)
    begin
      nxt_state.dt_st  = DT_IDLE;
      nxt_state.dt_cnt = DT_ZERO;
    end
    else if (phase_edge)
    begin
      if (dt_up && state_ff.opt_a[NARROW])
      begin
        nxt_state.dt_st = DT_DOWN;
      end
      else if (state_ff.dtw != DT_ZERO)
      begin
        nxt_state.dt_st  = DT_UP;
        nxt_state.dt_cnt = DT_ZERO;
      end
      else
      begin
        nxt_state.dt_st = DT_IDLE;
      end
    end
    else
    begin
      unique case (state_ff.dt_st)
        DT_IDLE:
        begin
          nxt_state.dt_cnt = DT_ZERO;
        end
        DT_UP:
        begin
          if (state_ff.dt_cnt >= state_ff.dtw)
          begin
            nxt_state.dt_st = DT_IDLE;
          end
          else
          begin
            nxt_state.dt_cnt = 8'(state_ff.dt_cnt + DT_STEP);
          end
        end
        DT_DOWN:
        begin
          if (state_ff.dt_cnt == DT_ZERO)
          begin
            nxt_state.dt_st = DT_IDLE;
          end
          else
          begin
            nxt_state.dt_cnt = 8'(state_ff.dt_cnt - DT_STEP);
          end
        end
        default:
        begin
          nxt_state.dt_st = DT_IDLE;
        end
      endcase
    end

    // A trigger in the same cycle as its clearing write stays set.
    nxt_state.sts = state_ff.sts;
    if (wr_acc && pstrb_i[0] && paddr_i == ADDR_STS)
    begin
      nxt_state.sts = state_ff.sts & ~wbyte[STS_W-1:0];
    end
    nxt_state.sts[STS_TRIG_A] = nxt_state.sts[STS_TRIG_A] | state_ff.trig_a;
    nxt_state.sts[STS_TRIG_B] = nxt_state.sts[STS_TRIG_B] | state_ff.trig_b;

    // Only lane 0 holds data; bit access is read-modify-write by software.
    if (wr_acc && pstrb_i[0])
    begin
      unique case (paddr_i)
        ADDR_OPT_A: nxt_state.opt_a = opt_a_new;
        ADDR_OPT_B: nxt_state.opt_b = wbyte & OPT_B_MASK;
        ADDR_CTRL:  nxt_state.ce    = wbyte[CTRL_CE];
        ADDR_DTW:   nxt_state.dtw   = wbyte;
        ADDR_MSK:   nxt_state.msk   = wbyte[STS_W-1:0];
        default:    nxt_state.ce    = state_ff.ce;
      endcase
    end

    if (setup_ph && !pwrite_i)
    begin
      unique case (paddr_i)
        ADDR_OPT_A: nxt_state.prdata = 32'(state_ff.opt_a & OPT_A_MASK);
        ADDR_OPT_B: nxt_state.prdata = 32'(state_ff.opt_b & OPT_B_MASK);
        ADDR_CTRL:  nxt_state.prdata = 32'(state_ff.ce);
        ADDR_DTW:   nxt_state.prdata = 32'(state_ff.dtw);
        ADDR_STS:   nxt_state.prdata = 32'(state_ff.sts);
        ADDR_MSK:   nxt_state.prdata = 32'(state_ff.msk);
        ADDR_STATE: nxt_state.prdata = 32'({state_ff.dt_cnt,
                                            state_ff.dt_st});
        default:    nxt_state.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      state_ff            <= '0;
      state_ff.opt_a      <= OPT_RST;
      state_ff.opt_b      <= OPT_RST;
      state_ff.dtw        <= DTW_RST;
      state_ff.dt_st      <= DT_IDLE;
      state_ff.sts        <= STS_RST;
      state_ff.msk        <= STS_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  logic [3:0] ev;
  logic       wr_opt_b;
  assign ev       = {companion_compare1_event_i, companion_compare0_event_i,
                     crest_event_i, valley_event_i};
  assign wr_opt_b = wr_acc && paddr_i == ADDR_OPT_B;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_cmp1_up_a: assert property (
    (state_ff.ce && companion_compare1_event_i && state_ff.opt_a[CMP1_EN]
     && !state_ff.opt_a[CMP1_PH] && state_ff.dt_st == DT_UP)
    |=> adc_trigger_out_a_o)
    else $error("Compare-1 up-phase trigger A missing.");

  a_cmp0_down_a: assert property (
    (state_ff.ce && companion_compare0_event_i && state_ff.opt_a[CMP0_EN]
     && state_ff.opt_a[CMP0_PH] && state_ff.dt_st == DT_UP)
    |=> !adc_trigger_out_a_o || $past(ev[3] || ev[1:0] != 2'b00))
    else $error("Compare-0 fired in the wrong dead-time phase.");

  a_cmp1_off_a: assert property (
    (ev == 4'b1000 && !state_ff.opt_a[CMP1_EN]) |=> !adc_trigger_out_a_o)
    else $error("Disabled compare-1 produced trigger A.");

  a_cmp0_off_a: assert property (
    (ev == 4'b0100 && !state_ff.opt_a[CMP0_EN]) |=> !adc_trigger_out_a_o)
    else $error("Disabled compare-0 produced trigger A.");

  a_crest_on_a: assert property (
    (state_ff.ce && crest_event_i && state_ff.opt_a[CREST_EN])
    |=> adc_trigger_out_a_o)
    else $error("Crest trigger A missing.");

  a_valley_off_a: assert property (
    (ev == 4'b0001 && !state_ff.opt_a[VALLEY_EN]) |=> !adc_trigger_out_a_o)
    else $error("Disabled valley produced trigger A.");

  a_crest_on_b: assert property (
    (state_ff.ce && crest_event_i && state_ff.opt_b[CREST_EN])
    |=> adc_trigger_out_b_o)
    else $error("Crest trigger B missing.");

  a_optb_write: assert property (
    (wr_opt_b && pstrb_i[0] && state_ff.ce)
    |=> state_ff.opt_b == ($past(pwdata_i[7:0]) & OPT_B_MASK))
    else $error("Second option write lost while counting.");

  a_optb_reset: assert property (@(posedge core_clk_i) disable iff (1'b0)
    !resetn_i |=> state_ff.opt_b == OPT_RST)
    else $error("Second option register not cleared by reset.");

  a_optb_lane: assert property (
    (wr_opt_b && !pstrb_i[0]) |=> $stable(state_ff.opt_b))
    else $error("Second option changed without its byte lane.");

  a_cmp1_down_b: assert property (
    (state_ff.ce && companion_compare1_event_i && state_ff.opt_b[CMP1_EN]
     && state_ff.opt_b[CMP1_PH] && state_ff.dt_st == DT_DOWN)
    |=> adc_trigger_out_b_o)
    else $error("Compare-1 down-phase trigger B missing.");

  a_optb_high_zero: assert property (
    (setup_ph && !pwrite_i && paddr_i == ADDR_OPT_B)
    |=> prdata_o[7:6] == 2'b00)
    else $error("Reserved bits of second option read nonzero.");

  a_narrow_rev: assert property (
    (state_ff.ce && phase_edge && state_ff.dt_st == DT_UP
     && state_ff.opt_a[NARROW])
    |=> state_ff.dt_st == DT_DOWN && state_ff.dt_cnt == $past(state_ff.dt_cnt))
    else $error("Dead-time counter did not reverse in narrow mode.");

  c_trig_a:  cover property (adc_trigger_out_a_o);
  c_trig_b:  cover property (adc_trigger_out_b_o);
  c_dt_down: cover property (state_ff.dt_st == DT_DOWN);
  c_irq:     cover property (irq_o);

endmodule // pats_top

`default_nettype wire

// File: tb/pats_adc_model.sv
`default_nettype none

module pats_adc_model
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        trig_a_i,
  input  wire logic        trig_b_i,
  output var int unsigned  conv_a_o,
  output var int unsigned  conv_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Every high cycle starts one conversion; the converter never stalls
  // the trigger path, so a missed or extra pulse shows in the counts.
  always @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      conv_a_o <= 0;
      conv_b_o <= 0;
    end
    else
    begin
      conv_a_o <= conv_a_o + trig_a_i;
      conv_b_o <= conv_b_o + trig_b_i;
    end
  end
endmodule // pats_adc_model

`default_nettype wire

// File: tb/testbench.sv
`default_nettype none

module testbench;
  import pats_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        phase;
  logic        pready;
  logic        pslverr;
  logic        trig_a;
  logic        trig_b;
  logic        irq;
  logic        err;
  logic [7:0]  paddr;
  logic [7:0]  oa;
  logic [7:0]  ob;
  logic [3:0]  pstrb;
  logic [3:0]  evt;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] s;
  int unsigned conv_a;
  int unsigned conv_b;
  int unsigned na;
  int unsigned nb;
  int unsigned fail_count;
  int unsigned checked;
  int          m;
  int          k;

  pats_top i_pats_top (.core_clk_i(clk), .resetn_i(resetn),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .companion_compare1_event_i(evt[3]),
    .companion_compare0_event_i(evt[2]),
    .crest_event_i(evt[1]), .valley_event_i(evt[0]),
    .phase_out_i(phase), .adc_trigger_out_a_o(trig_a),
    .adc_trigger_out_b_o(trig_b), .irq_o(irq));

  pats_adc_model i_pats_adc_model (.core_clk_i(clk), .resetn_i(resetn),
    .trig_a_i(trig_a), .trig_b_i(trig_b), .conv_a_o(conv_a),
    .conv_b_o(conv_b));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Mode 0 is the up phase, 1 the down phase, 2 idle, which is neither.
  function automatic logic expf(input int i, input logic [7:0] o,
                                input int md);
    if (i < 2)
      return o[i];
    return o[i] & (md != 2) & (o[i+2] == (md == 1));
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog may end a slave that never answers.
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic ev(input int i, input int md);
    logic ea;
    logic eb;
    ea = expf(i, oa, md);
    eb = expf(i, ob, md);
    @(posedge clk);
    evt <= 4'h1 << i;
    @(posedge clk);
    evt <= 4'h0;
    #1;
    chk("trig_a", ea, trig_a);
    chk("trig_b", eb, trig_b);
    na += ea;
    nb += eb;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100us;
    fail_count++;
    stop_test();
  end

  initial
  begin
    {resetn, psel, penable, pwrite, phase} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    evt = 4'h0;
    s = 32'd66250;
    {na, nb, fail_count, checked} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdchk(ADDR_OPT_B, 32'h0, "opt_b_rst");
    apb(1'b1, ADDR_OPT_B, 8'hff);
    rdchk(ADDR_OPT_B, 32'h3f, "opt_b_rsv");
    apb(1'b0, ADDR_OPT_B, 8'h00);
    apb(1'b1, ADDR_OPT_B, rd[7:0] & 8'hf7);
    rdchk(ADDR_OPT_B, 32'h37, "opt_b_bit");
    pstrb <= 4'h0;
    apb(1'b1, ADDR_OPT_B, 8'h00);
    pstrb <= 4'hf;
    rdchk(ADDR_OPT_B, 32'h37, "opt_b_lane");
    apb(1'b0, 8'h40, 8'h00);
    chk("slverr", 32'h1, err);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, ADDR_MSK, 8'h03);
    apb(1'b1, ADDR_CTRL, 8'h01);
    for (m = 0; m < 3; m++)
    begin
      if (m == 1)
      begin
        apb(1'b1, ADDR_CTRL, 8'h00);
        apb(1'b1, ADDR_OPT_A, 8'h40);
        apb(1'b1, ADDR_CTRL, 8'h01);
      end
      apb(1'b1, ADDR_DTW, (m == 2) ? 8'h00 : 8'hff);
      for (k = 0; k < 24; k++)
      begin
        s = lfsr(s);
        oa = s[7:0];
        ob = s[15:8];
        apb(1'b1, ADDR_OPT_A, oa);
        apb(1'b1, ADDR_OPT_B, ob);
        rdchk(ADDR_OPT_B, {24'h0, ob & OPT_B_MASK}, "opt_b");
        phase <= ~phase;
        if (m == 1)
        begin
          repeat (6) @(posedge clk);
          phase <= ~phase;
        end
        if (m == 1 && k == 0)
        begin
          @(posedge clk);
          apb(1'b0, ADDR_STATE, 8'h00);
          chk("dt_state", 32'h2, {30'h0, rd[1:0]});
        end
        else
          ev(int'(s[17:16]), m);
      end
    end
    apb(1'b1, ADDR_STS, 8'h03);
    #1;
    chk("irq_clr", 32'h0, irq);
    oa = 8'h02;
    ob = 8'h00;
    apb(1'b1, ADDR_OPT_A, oa);
    apb(1'b1, ADDR_OPT_B, ob);
    ev(1, 0);
    @(posedge clk);
    #1;
    chk("irq_set", 32'h1, irq);
    rdchk(ADDR_STS, 32'h1, "sts");
    apb(1'b1, ADDR_MSK, 8'h00);
    #1;
    chk("irq_msk", 32'h0, irq);
    @(posedge clk);
    chk("conv_a", na, conv_a);
    chk("conv_b", nb, conv_b);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdchk(ADDR_OPT_B, 32'h0, "opt_b_rst2");
    stop_test();
  end
endmodule // testbench

`default_nettype wire
